// [rtl/bacls_bank.sv]
// Purpose: audio configuration and link/input status registers of the bridge
// Assumes: one 25 MHz core clock; all status inputs synchronous to it
// Notes:   read data valid in the cycle after the read strobe only
//
// Function
// - audio config bit 7 enables the tdm-to-parallel converter and selects its clock for downstream audio.
// - audio config bit 6 drives received hdmi audio to the serial audio pins only while hdmi audio is the source.
// - audio config bit 3 clears the audio fifo when the incoming audio type changes.
// - audio config bit 2 clears the audio fifo when the audio infoframe checksum changes.
// - audio config bit 1 clears the audio fifo when the video information infoframe checksum changes.
// - audio config bit 0 clears the audio fifo when the clock regeneration n or cts value changes.
// - status bit 7 shows the downstream link is connected and its capabilities are known.
// - status bit 6 sets only with valid input, correct mode, transmitter active and far receiver locked.
// - status bits 5:4 report the port mode while bit 6 is set.
// - status bit 3 shows the receiver is recovering valid symbols.
// - status bit 2 shows the input pll is locked.
// - status bit 1 shows no input clock above the low-frequency limit.
// - status bit 0 shows the input frequency is stable.
// - audio source select chooses hdmi audio when clear and local serial audio when set.
// - the clock counts as stable only after staying in range for 40us, 80us, 320us or 1.28ms.
`timescale 1ns/1ps
`default_nettype none
module bacls_bank
    import bacls_pkg::*;
#(
    parameter int ACR_W  = 40,
    parameter int TYPE_W = 4,
    parameter int STB_C0 = BACLS_STB_C0,
    parameter int STB_C1 = BACLS_STB_C1,
    parameter int STB_C2 = BACLS_STB_C2,
    parameter int STB_C3 = BACLS_STB_C3
) (
    // clock, reset, enable
    input  wire logic                i_core_clk,
    input  wire logic                i_resetn,
    input  wire logic                i_ce,
    // register port
    input  wire logic [BACLS_AW-1:0] i_addr,
    input  wire logic [BACLS_DW-1:0] i_wdata,
    input  wire logic                i_wr,
    input  wire logic                i_rd,
    output logic      [BACLS_DW-1:0] o_rdata,
    // audio stream observations
    input  wire logic [TYPE_W-1:0]   i_audio_type,
    input  wire logic [7:0]          i_audio_frame_sum,
    input  wire logic [7:0]          i_video_frame_sum,
    input  wire logic [ACR_W-1:0]    i_clock_regen,
    input  wire logic                i_stream_valid,
    // link and input status sources
    input  wire logic                i_downstream_link_ready,
    input  wire logic                i_input_detected,
    input  wire logic                i_mode_settled,
    input  wire logic                i_transmitter_running,
    input  wire logic                i_far_receiver_locked,
    input  wire logic [1:0]          i_port_mode,
    input  wire logic                i_input_symbols_valid,
    input  wire logic                i_input_pll_locked,
    input  wire logic                i_clk_above_low_limit,
    input  wire logic                i_freq_in_hysteresis,
    // audio path control
    output logic                     o_tdm_converter_en,
    output logic                     o_use_converter_clk,
    output logic                     o_serial_audio_out_en,
    output logic                     o_local_audio_sel,
    output logic                     o_audio_fifo_clear,
    // interrupt
    output logic                     o_irq
);
    typedef struct packed {
        logic [7:0]           audio_cfg;
        logic [7:0]           bridge_cfg;
        logic [7:0]           fdet_cfg;
        logic [7:0]           status;
        logic [BACLS_NEV-1:0] int_sts;
        logic [BACLS_NEV-1:0] int_msk;
        logic [7:0]           rdata;
        logic                 tdm_en;
        logic                 conv_clk;
        logic                 i2s_out;
        logic                 local_sel;
        logic                 fifo_clr;
        logic                 irq;
    } bacls_bank_t;

    bacls_bank_t s_r;
    bacls_bank_t s_nxt;

    logic chg_type;
    logic chg_aif;
    logic chg_avi;
    logic chg_acr;

    bacls_fdet_if fd ();

    bacls_evt_detect #(.W(TYPE_W)) u_type (
        .i_core_clk (i_core_clk),
        .i_resetn   (i_resetn),
        .i_ce       (i_ce),
        .i_value    (i_audio_type),
        .i_valid    (i_stream_valid),
        .o_changed  (chg_type)
    );
    bacls_evt_detect #(.W(8)) u_aif (
        .i_core_clk (i_core_clk),
        .i_resetn   (i_resetn),
        .i_ce       (i_ce),
        .i_value    (i_audio_frame_sum),
        .i_valid    (i_stream_valid),
        .o_changed  (chg_aif)
    );
    bacls_evt_detect #(.W(8)) u_avi (
        .i_core_clk (i_core_clk),
        .i_resetn   (i_resetn),
        .i_ce       (i_ce),
        .i_value    (i_video_frame_sum),
        .i_valid    (i_stream_valid),
        .o_changed  (chg_avi)
    );
    bacls_evt_detect #(.W(ACR_W)) u_acr (
        .i_core_clk (i_core_clk),
        .i_resetn   (i_resetn),
        .i_ce       (i_ce),
        .i_value    (i_clock_regen),
        .i_valid    (i_stream_valid),
        .o_changed  (chg_acr)
    );

    bacls_stab_timer u_stab (
        .i_core_clk (i_core_clk),
        .i_resetn   (i_resetn),
        .i_ce       (i_ce),
        .fd         (fd.timer)
    );

    // window count from the threshold select; a count, so cut to the counter width
    function automatic logic [BACLS_CNT_W-1:0] window_of(input logic [1:0] sel);
        case (sel)
            2'h0:    window_of = BACLS_CNT_W'(STB_C0);
            2'h1:    window_of = BACLS_CNT_W'(STB_C1);
            2'h2:    window_of = BACLS_CNT_W'(STB_C2);
            default: window_of = BACLS_CNT_W'(STB_C3);
        endcase
    endfunction : window_of

    // write-one-to-clear with set winning over clear
    function automatic logic [BACLS_NEV-1:0] w1c(input logic [BACLS_NEV-1:0] cur,
                                                 input logic [BACLS_NEV-1:0] set,
                                                 input logic [BACLS_NEV-1:0] clr);
        w1c = (cur & ~clr) | set;
    endfunction : w1c

    assign fd.in_range    = i_freq_in_hysteresis;
    assign fd.clk_present = i_clk_above_low_limit;
    assign fd.window      = window_of(s_r.fdet_cfg[BACLS_FD_THR_HI:BACLS_FD_THR_LO]);

    logic                 tx_ok;
    logic [7:0]           st_new;
    logic                 wr_sts;
    logic [BACLS_NEV-1:0] ev;
    logic [BACLS_NEV-1:0] clr;

    always_comb begin
        s_nxt = s_r;

        // live status, sampled each cycle
        tx_ok = i_input_detected && i_mode_settled && i_transmitter_running
                && i_far_receiver_locked;
        st_new                     = BACLS_ZERO8;
        st_new[BACLS_ST_LINK_RDY]  = i_downstream_link_ready;
        st_new[BACLS_ST_TX_ACT]    = tx_ok;
        // port field only meaningful with the transmitter up; reads dual otherwise
        st_new[BACLS_ST_PORT_HI:BACLS_ST_PORT_LO] = tx_ok ? i_port_mode : BACLS_PORT_DUAL;
        st_new[BACLS_ST_SYM_VALID] = i_input_symbols_valid;
        st_new[BACLS_ST_PLL_LOCK]  = i_input_pll_locked;
        st_new[BACLS_ST_NO_CLK]    = !i_clk_above_low_limit;
        st_new[BACLS_ST_FREQ_STB]  = fd.stable;
        s_nxt.status = st_new;

        // register writes; the status address is read-only
        if (i_wr) begin
            case (i_addr)
                BACLS_AUDIO_CFG_ADR: s_nxt.audio_cfg  = i_wdata & BACLS_AUDIO_CFG_WM;
                BACLS_BRIDGE_ADR:    s_nxt.bridge_cfg = i_wdata;
                BACLS_FDET_ADR:      s_nxt.fdet_cfg   = i_wdata;
                BACLS_INT_MSK_ADR:   s_nxt.int_msk    = i_wdata[BACLS_NEV-1:0];
                default:             s_nxt.audio_cfg  = s_r.audio_cfg;
            endcase
        end

        // audio path steering
        s_nxt.tdm_en    = s_nxt.audio_cfg[BACLS_AC_TDM_PAR];
        s_nxt.conv_clk  = s_nxt.audio_cfg[BACLS_AC_TDM_PAR];
        s_nxt.local_sel = s_nxt.bridge_cfg[BACLS_BR_AUD_SRC];
        s_nxt.i2s_out   = s_nxt.audio_cfg[BACLS_AC_I2S_OUT]
                          && !s_nxt.bridge_cfg[BACLS_BR_AUD_SRC];

        // fifo clear on any enabled stream change
        s_nxt.fifo_clr = (s_r.audio_cfg[BACLS_AC_CLR_TYPE] && chg_type)
                      || (s_r.audio_cfg[BACLS_AC_CLR_AIF]  && chg_aif)
                      || (s_r.audio_cfg[BACLS_AC_CLR_AVI]  && chg_avi)
                      || (s_r.audio_cfg[BACLS_AC_CLR_ACR]  && chg_acr);

        // interrupt events
        ev                    = '0;
        ev[BACLS_EV_FIFO_CLR] = s_nxt.fifo_clr;
        ev[BACLS_EV_LINK_CHG] = st_new[BACLS_ST_TX_ACT] != s_r.status[BACLS_ST_TX_ACT];
        ev[BACLS_EV_STABLE]   = st_new[BACLS_ST_FREQ_STB] && !s_r.status[BACLS_ST_FREQ_STB];
        ev[BACLS_EV_NO_CLK]   = st_new[BACLS_ST_NO_CLK] && !s_r.status[BACLS_ST_NO_CLK];
        wr_sts = i_wr && (i_addr == BACLS_INT_STS_ADR);
        clr    = wr_sts ? i_wdata[BACLS_NEV-1:0] : '0;
        s_nxt.int_sts = w1c(s_r.int_sts, ev, clr);
        s_nxt.irq     = |(s_nxt.int_sts & s_nxt.int_msk);

        // read data stands for the one cycle after the strobe
        s_nxt.rdata = BACLS_ZERO8;
        if (i_rd) begin
            case (i_addr)
                BACLS_AUDIO_CFG_ADR: s_nxt.rdata = s_r.audio_cfg;
                BACLS_BRIDGE_ADR:    s_nxt.rdata = s_r.bridge_cfg;
                BACLS_STATUS_ADR:    s_nxt.rdata = s_r.status;
                BACLS_FDET_ADR:      s_nxt.rdata = s_r.fdet_cfg;
                BACLS_INT_STS_ADR:   s_nxt.rdata = {{(8-BACLS_NEV){1'b0}}, s_r.int_sts};
                BACLS_INT_MSK_ADR:   s_nxt.rdata = {{(8-BACLS_NEV){1'b0}}, s_r.int_msk};
                default:             s_nxt.rdata = BACLS_ZERO8;
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            s_r            <= '0;
            s_r.audio_cfg  <= BACLS_AUDIO_CFG_RST;
            s_r.fdet_cfg   <= BACLS_FDET_RST;
            s_r.status     <= BACLS_ZERO8;
        end else if (i_ce) begin
            s_r <= s_nxt;
        end
    end

    assign o_rdata               = s_r.rdata;
    assign o_tdm_converter_en    = s_r.tdm_en;
    assign o_use_converter_clk   = s_r.conv_clk;
    assign o_serial_audio_out_en = s_r.i2s_out;
    assign o_local_audio_sel     = s_r.local_sel;
    assign o_audio_fifo_clear    = s_r.fifo_clr;
    assign o_irq                 = s_r.irq;
endmodule : bacls_bank
`default_nettype wire

// [rtl/bacls_evt_detect.sv]
// Purpose: flags a change of a watched stream value as a one-cycle pulse
// Assumes: value is synchronous to the core clock
// Notes:   the first valid sample after reset only primes the history
`timescale 1ns/1ps
`default_nettype none
module bacls_evt_detect
    import bacls_pkg::*;
#(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         i_core_clk,
    input  wire logic         i_resetn,
    input  wire logic         i_ce,
    // watched value
    input  wire logic [W-1:0] i_value,
    input  wire logic         i_valid,
    output logic              o_changed
);
    typedef struct packed {
        logic [W-1:0] last;
        logic         primed;
        logic         chg;
    } bacls_ev_t;

    bacls_ev_t s_r;
    bacls_ev_t s_nxt;

    always_comb begin
        s_nxt     = s_r;
        s_nxt.chg = 1'b0;
        if (i_valid) begin
            s_nxt.last   = i_value;
            s_nxt.primed = 1'b1;
            s_nxt.chg    = s_r.primed && (i_value != s_r.last);
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            s_r <= '0;
        end else if (i_ce) begin
            s_r <= s_nxt;
        end
    end

    assign o_changed = s_r.chg;
endmodule : bacls_evt_detect
`default_nettype wire

// [rtl/bacls_fdet_if.sv]
// Purpose: carrier between the bank and its frequency stability timer
// Assumes: single core clock
// Notes:   window counts are sized by the bank
`timescale 1ns/1ps
`default_nettype none
interface bacls_fdet_if;
    import bacls_pkg::*;
    logic                   in_range;
    logic                   clk_present;
    logic [BACLS_CNT_W-1:0] window;
    logic                   stable;

    modport bank  (output in_range, output clk_present, output window, input stable);
    modport timer (input in_range, input clk_present, input window, output stable);
endinterface : bacls_fdet_if
`default_nettype wire

// [rtl/bacls_pkg.sv]
// Purpose: shared constants and types for the audio configuration and link status bank
// Assumes: 25 MHz core clock, 8-bit register port
// Notes:   offsets are byte addresses on the plain register port
package bacls_pkg;

    localparam int          BACLS_CLK_MHZ       = 25;
    localparam int          BACLS_AW            = 8;
    localparam int          BACLS_DW            = 8;

    // register map
    localparam logic [7:0]  BACLS_AUDIO_CFG_ADR = 8'h55;
    localparam logic [7:0]  BACLS_BRIDGE_ADR    = 8'h56;
    localparam logic [7:0]  BACLS_STATUS_ADR    = 8'h5a;
    localparam logic [7:0]  BACLS_FDET_ADR      = 8'h5c;
    localparam logic [7:0]  BACLS_INT_STS_ADR   = 8'h60;
    localparam logic [7:0]  BACLS_INT_MSK_ADR   = 8'h61;

    // reset values and the audio config write mask
    localparam logic [7:0]  BACLS_AUDIO_CFG_RST = 8'h0c;
    localparam logic [7:0]  BACLS_AUDIO_CFG_WM  = 8'hcf;
    localparam logic [7:0]  BACLS_FDET_RST      = 8'h02;
    localparam logic [7:0]  BACLS_ZERO8         = 8'h00;

    // audio configuration bit positions
    localparam int          BACLS_AC_TDM_PAR    = 7;
    localparam int          BACLS_AC_I2S_OUT    = 6;
    localparam int          BACLS_AC_CLR_TYPE   = 3;
    localparam int          BACLS_AC_CLR_AIF    = 2;
    localparam int          BACLS_AC_CLR_AVI    = 1;
    localparam int          BACLS_AC_CLR_ACR    = 0;

    // bridge config: audio source select
    localparam int          BACLS_BR_AUD_SRC    = 1;

    // frequency detect register fields
    localparam int          BACLS_FD_THR_LO     = 3;
    localparam int          BACLS_FD_THR_HI     = 4;

    // status bit positions
    localparam int          BACLS_ST_LINK_RDY   = 7;
    localparam int          BACLS_ST_TX_ACT     = 6;
    localparam int          BACLS_ST_PORT_HI    = 5;
    localparam int          BACLS_ST_PORT_LO    = 4;
    localparam int          BACLS_ST_SYM_VALID  = 3;
    localparam int          BACLS_ST_PLL_LOCK   = 2;
    localparam int          BACLS_ST_NO_CLK     = 1;
    localparam int          BACLS_ST_FREQ_STB   = 0;

    // interrupt event bits
    localparam int          BACLS_EV_FIFO_CLR   = 0;
    localparam int          BACLS_EV_LINK_CHG   = 1;
    localparam int          BACLS_EV_STABLE     = 2;
    localparam int          BACLS_EV_NO_CLK     = 3;
    localparam int          BACLS_NEV           = 4;

    // stability windows, in microseconds, and the cycle counts derived
    localparam int          BACLS_STB_T0_US     = 40;
    localparam int          BACLS_STB_T1_US     = 80;
    localparam int          BACLS_STB_T2_US     = 320;
    localparam int          BACLS_STB_T3_US     = 1280;
    localparam int          BACLS_STB_C0        = BACLS_STB_T0_US * BACLS_CLK_MHZ;
    localparam int          BACLS_STB_C1        = BACLS_STB_T1_US * BACLS_CLK_MHZ;
    localparam int          BACLS_STB_C2        = BACLS_STB_T2_US * BACLS_CLK_MHZ;
    localparam int          BACLS_STB_C3        = BACLS_STB_T3_US * BACLS_CLK_MHZ;
    localparam int          BACLS_CNT_W         = 16;

    localparam logic [1:0]  BACLS_PORT_DUAL     = 2'h0;

    typedef enum logic [2:0] {
        BACLS_FD_IDLE   = 3'b001,
        BACLS_FD_WAIT   = 3'b010,
        BACLS_FD_STABLE = 3'b100
    } bacls_fd_state_t;

endpackage : bacls_pkg

// [rtl/bacls_stab_timer.sv]
// Purpose: declares the input clock stable after it stays in range for a window
// Assumes: in_range and clk_present are synchronous to the core clock
// Notes:   any excursion restarts the window
`timescale 1ns/1ps
`default_nettype none
module bacls_stab_timer
    import bacls_pkg::*;
(
    // clock and reset
    input  wire logic  i_core_clk,
    input  wire logic  i_resetn,
    input  wire logic  i_ce,
    // measurement side
    bacls_fdet_if.timer fd
);
    typedef struct packed {
        bacls_fd_state_t        st;
        logic [BACLS_CNT_W-1:0] cnt;
    } bacls_tm_t;

    bacls_tm_t s_r;
    bacls_tm_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (!fd.clk_present || !fd.in_range) begin
            s_nxt.st  = BACLS_FD_IDLE;
            s_nxt.cnt = '0;
        end else begin
            case (s_r.st)
                BACLS_FD_IDLE: begin
                    s_nxt.st  = BACLS_FD_WAIT;
                    s_nxt.cnt = 16'h0001;
                end
                BACLS_FD_WAIT: begin
                    // stable only after the full selected window in range
                    if (s_r.cnt >= fd.window) begin
                        s_nxt.st = BACLS_FD_STABLE;
                    end else begin
                        s_nxt.cnt = s_r.cnt + 16'h0001;
                    end
                end
                BACLS_FD_STABLE: s_nxt = s_r;
                default: begin
                    s_nxt.st  = BACLS_FD_IDLE;
                    s_nxt.cnt = '0;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            s_r.st  <= BACLS_FD_IDLE;
            s_r.cnt <= '0;
        end else if (i_ce) begin
            s_r <= s_nxt;
        end
    end

    assign fd.stable = (s_r.st == BACLS_FD_STABLE);
endmodule : bacls_stab_timer
`default_nettype wire

// [testbench/bacls_bank_sva.sv]
// Purpose: assertions on the audio config and link status bank ports
// Assumes: one core clock, asynchronous active-low reset
// Notes:   status checks need the sources steady across the read
`timescale 1ns/1ps
`default_nettype none
module bacls_bank_sva (
    // clock and reset
    input wire logic       i_core_clk,
    input wire logic       i_resetn,
    input wire logic       i_ce,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] o_rdata,
    // status sources
    input wire logic       i_downstream_link_ready,
    input wire logic       i_input_detected,
    input wire logic       i_mode_settled,
    input wire logic       i_transmitter_running,
    input wire logic       i_far_receiver_locked,
    input wire logic [1:0] i_port_mode,
    input wire logic       i_input_symbols_valid,
    input wire logic       i_input_pll_locked,
    input wire logic       i_clk_above_low_limit,
    input wire logic       i_stream_valid,
    // audio control
    input wire logic       o_tdm_converter_en,
    input wire logic       o_use_converter_clk,
    input wire logic       o_serial_audio_out_en,
    input wire logic       o_local_audio_sel,
    input wire logic       o_audio_fifo_clear
);
    logic tx_ok;
    assign tx_ok = i_input_detected && i_mode_settled && i_transmitter_running && i_far_receiver_locked;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);
    sequence s_cfg_wr;
        i_ce && i_wr && i_addr == 8'h55;
    endsequence
    // the status register samples its sources one cycle before the read is served
    sequence s_sts_rd;
        $past(i_resetn) && $past(i_ce) && i_ce && i_rd && i_addr == 8'h5a && $stable({tx_ok, i_port_mode,
            i_downstream_link_ready, i_input_symbols_valid, i_input_pll_locked, i_clk_above_low_limit}) ##1 1'b1;
    endsequence
    AST_TDM_EN: assert property (s_cfg_wr |=> o_tdm_converter_en == $past(i_wdata[7])
        && o_use_converter_clk == $past(i_wdata[7])) else $error("converter enable differs from bit 7");
    AST_I2S_OUT: assert property (s_cfg_wr |=>
        o_serial_audio_out_en == ($past(i_wdata[6]) && !o_local_audio_sel)) else $error("audio pin enable wrong");
    AST_FIFO_CLR: assert property (o_audio_fifo_clear |-> $past(i_stream_valid, 2))
        else $error("fifo clear without a valid sample");
    AST_RSV: assert property (i_ce && i_rd && i_addr == 8'h55 |=> o_rdata[5:4] == 2'h0)
        else $error("reserved config bits not zero");
    AST_LINK: assert property (s_sts_rd |-> o_rdata[7] == $past(i_downstream_link_ready))
        else $error("link ready bit wrong");
    AST_TX_ACT: assert property (s_sts_rd |-> o_rdata[6] == $past(tx_ok))
        else $error("transmitter active bit wrong");
    AST_PORT: assert property (s_sts_rd |-> o_rdata[5:4] == (o_rdata[6] ? $past(i_port_mode) : 2'h0))
        else $error("port mode field wrong");
    AST_SYM: assert property (s_sts_rd |-> o_rdata[3] == $past(i_input_symbols_valid))
        else $error("symbol valid bit wrong");
    AST_PLL: assert property (s_sts_rd |-> o_rdata[2] == $past(i_input_pll_locked))
        else $error("pll lock bit wrong");
    AST_NO_CLK: assert property (s_sts_rd |-> o_rdata[1] == !$past(i_clk_above_low_limit))
        else $error("no clock bit wrong");
endmodule : bacls_bank_sva
bind bacls_bank bacls_bank_sva u_sva (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_ce(i_ce),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_downstream_link_ready(i_downstream_link_ready), .i_input_detected(i_input_detected),
    .i_mode_settled(i_mode_settled), .i_transmitter_running(i_transmitter_running),
    .i_far_receiver_locked(i_far_receiver_locked), .i_port_mode(i_port_mode),
    .i_input_symbols_valid(i_input_symbols_valid), .i_input_pll_locked(i_input_pll_locked),
    .i_clk_above_low_limit(i_clk_above_low_limit), .i_stream_valid(i_stream_valid),
    .o_tdm_converter_en(o_tdm_converter_en), .o_use_converter_clk(o_use_converter_clk),
    .o_serial_audio_out_en(o_serial_audio_out_en), .o_local_audio_sel(o_local_audio_sel),
    .o_audio_fifo_clear(o_audio_fifo_clear));
`default_nettype wire

// [testbench/bacls_bank_test.sv]
// Purpose: self-checking bench for the audio config and link status bank
// Assumes: clock enable held high; windows shortened to 4, 8, 16 and 32 cycles
// Notes:   bus tasks start at a rising edge; bwr finishes on the next one, rchk just after it
`timescale 1ns/1ps
`default_nettype none
module bacls_bank_test
    import bacls_pkg::*;
;
    logic        clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, sv = 1'b1;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, afs = 8'h00, vfs = 8'h00;
    logic [3:0]  atype = 4'h0;
    logic [39:0] regen = 40'h0;
    logic        lrdy = 1'b0, det = 1'b0, setl = 1'b0, run = 1'b0, lck = 1'b0, sym = 1'b0, pll = 1'b0;
    logic        clkok = 1'b0, hys = 1'b0, tdm, ucl, sao, lsel, fclr, irq;
    logic [1:0]  pm = 2'h0;
    int          errors = 0, cmp_count = 0;

    always #20 clk = ~clk;

    bacls_bank #(.STB_C0(4), .STB_C1(8), .STB_C2(16), .STB_C3(32)) u_dut (
        .i_core_clk(clk), .i_resetn(rstn), .i_ce(1'b1), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .i_audio_type(atype), .i_audio_frame_sum(afs), .i_video_frame_sum(vfs),
        .i_clock_regen(regen), .i_stream_valid(sv), .i_downstream_link_ready(lrdy), .i_input_detected(det),
        .i_mode_settled(setl), .i_transmitter_running(run), .i_far_receiver_locked(lck), .i_port_mode(pm),
        .i_input_symbols_valid(sym), .i_input_pll_locked(pll), .i_clk_above_low_limit(clkok),
        .i_freq_in_hysteresis(hys), .o_tdm_converter_en(tdm), .o_use_converter_clk(ucl),
        .o_serial_audio_out_en(sao), .o_local_audio_sel(lsel), .o_audio_fifo_clear(fclr), .o_irq(irq));

    task automatic finish_test;
        if (errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic bwr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : bwr

    // read data stands only in the cycle after the strobe, so it is caught there
    task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(n, e, rdata);
    endtask : rchk

    task automatic t_cfg;
        rchk("status_idle", 8'h5a, 8'h02);
        rchk("unmapped", 8'h70, 8'h00);
        bwr(8'h55, 8'hff);
        #1 chk("tdm_en", 8'h01, 8'(tdm));
        chk("conv_clk", 8'h01, 8'(ucl));
        chk("i2s_out", 8'h01, 8'(sao));
        rchk("cfg_rsvd", 8'h55, 8'hcf);
        bwr(8'h56, 8'h02);
        #1 chk("local_sel", 8'h01, 8'(lsel));
        chk("i2s_out_local", 8'h00, 8'(sao));
        bwr(8'h56, 8'h00);
        bwr(8'h55, 8'h40);
        #1 chk("tdm_off", 8'h00, 8'(tdm));
        chk("i2s_out_hdmi", 8'h01, 8'(sao));
        bwr(8'h5a, 8'hff);
        rchk("status_ro", 8'h5a, 8'h02);
    endtask : t_cfg

    task automatic t_status;
        for (int k = 0; k < 8; k++) begin
            @(posedge clk);
            {det, setl, run, lck} <= (k < 4) ? 4'hf : ~(4'h1 << (k - 4));
            pm <= 2'(k);
            lrdy <= k[0];
            sym <= k[1];
            pll <= k[2];
            clkok <= k[0];
            rchk("status", 8'h5a, {k[0], k < 4, (k < 4) ? 2'(k) : 2'h0, k[1], k[2], !k[0], 1'b0});
        end
    endtask : t_status

    task automatic t_fifo;
        logic [7:0] hits;
        for (int b = 0; b < 4; b++) begin
            bwr(8'h55, 8'h01 << b);
            for (int j = 0; j < 4; j++) begin
                @(posedge clk);
                case (j)
                    0: regen <= regen + 40'h1;
                    1: vfs <= vfs + 8'h1;
                    2: afs <= afs + 8'h1;
                    default: atype <= atype + 4'h1;
                endcase
                hits = 8'h00;
                // an unknown pulse must poison the count rather than read as zero
                repeat (5) begin
                    @(posedge clk);
                    #1 hits += 8'(fclr);
                end
                chk("fifo_clear", 8'(b == j), hits);
            end
        end
    endtask : t_fifo

    task automatic t_stable;
        bwr(8'h61, 8'h04);
        for (int s = 0; s < 4; s++) begin
            bwr(8'h5c, 8'(s << 3));
            @(posedge clk);
            clkok <= 1'b1;
            hys <= 1'b0;
            bwr(8'h60, 8'h0f);
            @(posedge clk);
            hys <= 1'b1;
            repeat ((4 << s) - 4) @(posedge clk);
            // link ready, symbols valid and pll lock are still up from the last status step
            rchk("not_yet_stable", 8'h5a, 8'h8c);
            repeat (6) @(posedge clk);
            rchk("stable", 8'h5a, 8'h8d);
        end
        chk("irq_on", 8'h01, 8'(irq));
        bwr(8'h61, 8'h00);
        #1 chk("irq_masked", 8'h00, 8'(irq));
        bwr(8'h61, 8'h04);
        @(posedge clk);
        #1 chk("irq_unmasked", 8'h01, 8'(irq));
        bwr(8'h60, 8'h04);
        @(posedge clk);
        #1 chk("irq_cleared", 8'h00, 8'(irq));
    endtask : t_stable

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        finish_test();
    end

    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        t_cfg();
        t_status();
        t_fifo();
        t_stable();
        finish_test();
    end
endmodule : bacls_bank_test
`default_nettype wire
